// file: logic/stack_addr_pkg.sv
// Purpose: shared constants and types for stack and operand addressing
// Assumes: 8-bit register file, 16-bit memory address bus
// Notes: none
package stack_addr_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] STACK_TOP_POINTER_ADDR = 8'hD9;
  localparam logic [7:0] WORK_BASE = 8'hC0;
  localparam logic [7:0] GP_TOP = 8'hB7;
  localparam logic [7:0] FLAGS_ADDR = 8'hD5;
  // ==========================================================
  // operations and modes
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_PUSH = 4'h1,
    OP_POP = 4'h2,
    OP_CALL = 4'h3,
    OP_RET = 4'h4,
    OP_INT = 4'h5,
    OP_INTERRUPT_EXIT_INSTRUCTION = 4'h6,
    OP_JUMP = 4'h7,
    OP_BRANCH = 4'h8
  } stack_op_e;
  typedef enum logic [2:0] {
    AM_REG = 3'h0,
    AM_WORK = 3'h1,
    AM_POINTER = 3'h2,
    AM_INDEX_RF = 3'h3,
    AM_INDEX_MEM = 3'h4,
    AM_DIRECT = 3'h5,
    AM_LITERAL = 3'h6
  } addr_mode_e;
  typedef enum logic [1:0] {
    INS_GENERAL_MOVE = 2'h0,
    INS_PROGRAM_MEMORY_LOAD = 2'h1,
    INS_EXTERNAL_DATA_LOAD = 2'h2,
    INS_OTHER = 2'h3
  } ins_class_e;
  typedef struct packed {
    addr_mode_e mode;
    ins_class_e ins;
    logic working;
    logic long_offset;
    logic [7:0] reg_field;
    logic [15:0] imm;
  } operand_req_s;
  typedef struct packed {
    logic rf_valid;
    logic [7:0] rf_addr;
    logic mem_valid;
    logic [15:0] mem_addr;
    logic lit_valid;
    logic [7:0] lit;
    logic illegal;
  } operand_res_s;
  // stack sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_PUSH_LO = 7'h02,
    ST_PUSH_HI = 7'h04,
    ST_PUSH_FL = 7'h08,
    ST_POP_FL = 7'h10,
    ST_POP_HI = 7'h20,
    ST_POP_LO = 7'h40
  } stack_state_e;
endpackage : stack_addr_pkg

// file: logic/operand_addr_gen.sv
// Purpose: effective address forming for operand addressing modes
// Assumes: register reads of bases arrive from the register file
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module operand_addr_gen (
  input wire stack_addr_pkg::operand_req_s req,
  input wire logic [7:0] work_byte,
  input wire logic [15:0] work_pair,
  input wire logic [7:0] reg_byte,
  input wire logic [15:0] reg_pair,
  output stack_addr_pkg::operand_res_s res
);
  // ==========================================================
  // address forming
  logic [15:0] disp;
  logic [7:0] work_addr;
  always_comb begin
    res = '0;
    disp = req.long_offset ? req.imm : {{8{req.imm[7]}}, req.imm[7:0]};
    work_addr = stack_addr_pkg::WORK_BASE | {4'h0, req.reg_field[3:0]};
    case (req.mode)
      stack_addr_pkg::AM_REG: begin
        res.rf_valid = 1'b1;
        res.rf_addr = req.reg_field;
      end
      stack_addr_pkg::AM_WORK: begin
        res.rf_valid = 1'b1;
        res.rf_addr = work_addr;
      end
      stack_addr_pkg::AM_POINTER: begin
        if (req.ins == stack_addr_pkg::INS_GENERAL_MOVE) begin
          res.rf_valid = 1'b1;
          res.rf_addr = req.working ? work_byte : reg_byte;
        end else begin
          res.mem_valid = 1'b1;
          res.mem_addr = req.working ? work_pair : reg_pair;
        end
      end
      stack_addr_pkg::AM_INDEX_RF: begin
        res.rf_valid = req.ins == stack_addr_pkg::INS_GENERAL_MOVE;
        res.illegal = req.ins != stack_addr_pkg::INS_GENERAL_MOVE;
        res.rf_addr = req.imm[7:0] + work_byte;
      end
      stack_addr_pkg::AM_INDEX_MEM: begin
        res.mem_valid = (req.ins == stack_addr_pkg::INS_PROGRAM_MEMORY_LOAD) ||
          (req.ins == stack_addr_pkg::INS_EXTERNAL_DATA_LOAD);
        res.illegal = !res.mem_valid;
        res.mem_addr = work_pair + disp;
      end
      stack_addr_pkg::AM_DIRECT: begin
        res.mem_valid = 1'b1;
        res.mem_addr = req.imm;
      end
      stack_addr_pkg::AM_LITERAL: begin
        res.lit_valid = 1'b1;
        res.lit = req.imm[7:0];
      end
      default: res.illegal = 1'b1;
    endcase
  end
endmodule : operand_addr_gen
`default_nettype wire

// file: logic/stack_addr_unit.sv
// Function
// - call saves pc, return restores it
// - interrupt pushes pc and flags, interrupt_exit_instruction pops
// - predecrement on push, postincrement on pop
// - pointer addresses most recently pushed byte
// - 8-bit pointer mapped at D9H, read/write; bus writes taken only while the sequencer is idle
// - pointer reset value left undefined
// - pointer arithmetic wraps within eight bits
// - register mode reads named register
// - working mode uses 4-bit number
// - pointer mode uses register contents as address
// - indexed register file: base plus working offset
// - indexed memory: pair base plus offset
// - short offset is sign extended
// - indexing limited per load instruction class
// - direct address loads pc on jumps
// - memory loads accept direct address
// - relative displacement added to pc
// - displacement relative to following instruction
// - literal operand taken from instruction
// - pairs even address, high byte first; stack pairs land at whatever the pointer holds, with no even alignment
// - working registers map to C0H-CFH
// Purpose: stack sequencing, pc load and operand address generation
// Assumes: register file write takes effect at the clock edge
// Notes: pc_next_in is the address after the current instruction
`timescale 1ns/1ps
`default_nettype none
module stack_addr_unit (
  input wire logic clk,
  input wire logic rst,
  input wire stack_addr_pkg::stack_op_e op,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [7:0] push_data,
  input wire logic [15:0] pc_next_in,
  input wire logic [15:0] op_imm,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] rf_rdata,
  input wire logic [7:0] bus_addr,
  input wire logic bus_we,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic [7:0] rf_addr,
  output logic rf_we,
  output logic [7:0] rf_wdata,
  output logic pop_valid,
  output logic [7:0] pop_data,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic flags_load,
  output logic [7:0] flags_value,
  output logic [7:0] stack_top_pointer,
  input wire stack_addr_pkg::operand_req_s operand_req,
  input wire logic [7:0] work_byte,
  input wire logic [15:0] work_pair,
  input wire logic [7:0] reg_byte,
  input wire logic [15:0] reg_pair,
  output stack_addr_pkg::operand_res_s operand_res
);
  // ==========================================================
  // state
  stack_addr_pkg::stack_state_e state_q, state_d;
  logic [7:0] sp_q, sp_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] hi_q, hi_d;
  logic ret_int_q, ret_int_d;
  logic pc_load_q, pc_load_d;
  logic flags_load_q, flags_load_d;
  logic [7:0] flags_q, flags_d;
  logic pop_valid_q, pop_valid_d;
  logic [7:0] pop_data_q, pop_data_d;
  logic sp_sel;
  logic [15:0] rel_sum;

  assign sp_sel = bus_we && (bus_addr == stack_addr_pkg::STACK_TOP_POINTER_ADDR);
  assign rel_sum = pc_next_in + {{8{op_imm[7]}}, op_imm[7:0]};
  assign op_ready = state_q == stack_addr_pkg::ST_IDLE;
  assign stack_top_pointer = sp_q;
  assign bus_rdata = (bus_addr == stack_addr_pkg::STACK_TOP_POINTER_ADDR) ? sp_q : 8'h00;
  assign pc_load = pc_load_q;
  assign pc_value = pc_q;
  assign flags_load = flags_load_q;
  assign flags_value = flags_q;
  assign pop_valid = pop_valid_q;
  assign pop_data = pop_data_q;

  // ==========================================================
  // stack sequencer
  always_comb begin
    state_d = state_q;
    sp_d = sp_q;
    pc_d = pc_q;
    hi_d = hi_q;
    ret_int_d = ret_int_q;
    pc_load_d = 1'b0;
    flags_load_d = 1'b0;
    flags_d = flags_q;
    pop_valid_d = 1'b0;
    pop_data_d = pop_data_q;
    rf_we = 1'b0;
    rf_addr = sp_q;
    rf_wdata = 8'h00;
    case (state_q)
      stack_addr_pkg::ST_IDLE: begin
        if (sp_sel) begin
          sp_d = bus_wdata;
        end else if (op_valid) begin
          case (op)
            stack_addr_pkg::OP_PUSH: begin
              sp_d = sp_q - 8'h01;
              rf_addr = sp_d;
              rf_we = 1'b1;
              rf_wdata = push_data;
            end
            stack_addr_pkg::OP_POP: begin
              pop_valid_d = 1'b1;
              pop_data_d = rf_rdata;
              sp_d = sp_q + 8'h01;
            end
            stack_addr_pkg::OP_CALL: begin
              pc_d = op_imm;
              hi_d = pc_next_in[15:8];
              sp_d = sp_q - 8'h01;
              rf_addr = sp_d;
              rf_we = 1'b1;
              rf_wdata = pc_next_in[7:0];
              state_d = stack_addr_pkg::ST_PUSH_HI;
            end
            stack_addr_pkg::OP_INT: begin
              hi_d = pc_next_in[15:8];
              pc_d = pc_next_in;
              flags_d = flags_in;
              sp_d = sp_q - 8'h01;
              rf_addr = sp_d;
              rf_we = 1'b1;
              rf_wdata = pc_next_in[7:0];
              state_d = stack_addr_pkg::ST_PUSH_HI;
              ret_int_d = 1'b1;
            end
            stack_addr_pkg::OP_RET: begin
              ret_int_d = 1'b0;
              state_d = stack_addr_pkg::ST_POP_HI;
            end
            stack_addr_pkg::OP_INTERRUPT_EXIT_INSTRUCTION: begin
              ret_int_d = 1'b1;
              state_d = stack_addr_pkg::ST_POP_FL;
            end
            stack_addr_pkg::OP_JUMP: begin
              pc_d = op_imm;
              pc_load_d = 1'b1;
            end
            stack_addr_pkg::OP_BRANCH: begin
              pc_d = rel_sum;
              pc_load_d = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      stack_addr_pkg::ST_PUSH_HI: begin
        sp_d = sp_q - 8'h01;
        rf_addr = sp_d;
        rf_we = 1'b1;
        rf_wdata = hi_q;
        if (ret_int_q) begin
          state_d = stack_addr_pkg::ST_PUSH_FL;
        end else begin
          pc_load_d = 1'b1;
          state_d = stack_addr_pkg::ST_IDLE;
        end
      end
      stack_addr_pkg::ST_PUSH_FL: begin
        sp_d = sp_q - 8'h01;
        rf_addr = sp_d;
        rf_we = 1'b1;
        rf_wdata = flags_q;
        ret_int_d = 1'b0;
        state_d = stack_addr_pkg::ST_IDLE;
      end
      stack_addr_pkg::ST_POP_FL: begin
        flags_d = rf_rdata;
        flags_load_d = 1'b1;
        sp_d = sp_q + 8'h01;
        state_d = stack_addr_pkg::ST_POP_HI;
      end
      stack_addr_pkg::ST_POP_HI: begin
        hi_d = rf_rdata;
        sp_d = sp_q + 8'h01;
        state_d = stack_addr_pkg::ST_POP_LO;
      end
      stack_addr_pkg::ST_POP_LO: begin
        pc_d = {hi_q, rf_rdata};
        pc_load_d = 1'b1;
        sp_d = sp_q + 8'h01;
        ret_int_d = 1'b0;
        state_d = stack_addr_pkg::ST_IDLE;
      end
      default: state_d = stack_addr_pkg::ST_IDLE;
    endcase
  end

  // pointer has no reset, its value is undefined after reset
  always_ff @(posedge clk) begin
    sp_q <= sp_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= stack_addr_pkg::ST_IDLE;
      pc_q <= 16'h0000;
      hi_q <= 8'h00;
      ret_int_q <= 1'b0;
      pc_load_q <= 1'b0;
      flags_load_q <= 1'b0;
      flags_q <= 8'h00;
      pop_valid_q <= 1'b0;
      pop_data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      hi_q <= hi_d;
      ret_int_q <= ret_int_d;
      pc_load_q <= pc_load_d;
      flags_load_q <= flags_load_d;
      flags_q <= flags_d;
      pop_valid_q <= pop_valid_d;
      pop_data_q <= pop_data_d;
    end
  end

  // ==========================================================
  // operand addressing
  operand_addr_gen u_operand_addr_gen (
    .req(operand_req),
    .work_byte(work_byte),
    .work_pair(work_pair),
    .reg_byte(reg_byte),
    .reg_pair(reg_pair),
    .res(operand_res)
  );

  // ==========================================================
  // checks
  property p_push_predec;
    @(posedge clk) disable iff (rst)
      (op_ready && op_valid && !sp_sel && op == stack_addr_pkg::OP_PUSH)
      |-> rf_we && rf_addr == sp_q - 8'h01 ##1 sp_q == $past(sp_q) - 8'h01;
  endproperty
  a_push_predec: assert property (p_push_predec) else $error("push did not predecrement");

  property p_pop_postinc;
    @(posedge clk) disable iff (rst)
      (op_ready && op_valid && !sp_sel && op == stack_addr_pkg::OP_POP)
      |-> rf_addr == sp_q ##1 pop_valid && sp_q == $past(sp_q) + 8'h01;
  endproperty
  a_pop_postinc: assert property (p_pop_postinc) else $error("pop did not postincrement");

  property p_call_seq;
    @(posedge clk) disable iff (rst)
      (op_ready && op_valid && !sp_sel && op == stack_addr_pkg::OP_CALL)
      |-> ##1 (rf_we && rf_wdata == $past(pc_next_in[15:8]))
      ##1 (pc_load && pc_value == $past(op_imm, 2));
  endproperty
  a_call_seq: assert property (p_call_seq) else $error("call sequence wrong");

  property p_int_three;
    @(posedge clk) disable iff (rst)
      (op_ready && op_valid && !sp_sel && op == stack_addr_pkg::OP_INT)
      |-> rf_we ##1 rf_we ##1 (rf_we && rf_wdata == $past(flags_in, 2)) ##1 op_ready;
  endproperty
  a_int_three: assert property (p_int_three) else $error("interrupt entry wrong");

  property p_interrupt_exit_instruction_pop;
    @(posedge clk) disable iff (rst)
      (op_ready && op_valid && !sp_sel && op == stack_addr_pkg::OP_INTERRUPT_EXIT_INSTRUCTION)
      |-> ##1 !op_ready
      ##1 (flags_load && !op_ready && flags_value == $past(rf_rdata))
      ##1 !op_ready
      ##1 (pc_load && op_ready && sp_q == $past(sp_q, 4) + 8'h03);
  endproperty
  a_interrupt_exit_instruction_pop: assert property (p_interrupt_exit_instruction_pop) else $error("interrupt exit wrong");

  property p_wrap;
    @(posedge clk) disable iff (rst)
      (op_ready && op_valid && !sp_sel && op == stack_addr_pkg::OP_PUSH && sp_q == 8'h00)
      |=> sp_q == 8'hFF;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  property p_branch;
    @(posedge clk) disable iff (rst)
      (op_ready && op_valid && !sp_sel && op == stack_addr_pkg::OP_BRANCH)
      |=> pc_load && pc_value == $past(pc_next_in) + {{8{$past(op_imm[7])}}, $past(op_imm[7:0])};
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");

  property p_sp_write;
    @(posedge clk) disable iff (rst)
      (op_ready && sp_sel) |=> stack_top_pointer == $past(bus_wdata)
      && (bus_rdata == $past(bus_wdata) || bus_addr != stack_addr_pkg::STACK_TOP_POINTER_ADDR);
  endproperty
  a_sp_write: assert property (p_sp_write) else $error("pointer write lost");

  property p_work_map;
    @(posedge clk) disable iff (rst)
      operand_req.mode == stack_addr_pkg::AM_WORK |-> operand_res.rf_addr[7:4] == 4'hC;
  endproperty
  a_work_map: assert property (p_work_map) else $error("working register off common area");
endmodule : stack_addr_unit
`default_nettype wire

// file: sim/reg_file_model.sv
// Purpose: register file model behind the stack port
// Assumes: write lands at the clock edge, read is combinational
// Notes: unwritten bytes read unknown
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
  input wire logic clk,
  input wire logic [7:0] rf_addr,
  input wire logic rf_we,
  input wire logic [7:0] rf_wdata,
  output logic [7:0] rf_rdata
);
  // ==========================================
  // storage
  logic [7:0] mem [0:255];
  assign rf_rdata = mem[rf_addr];
  always_ff @(posedge clk) begin
    if (rf_we) begin
      mem[rf_addr] <= rf_wdata;
    end
  end
endmodule : reg_file_model
`default_nettype wire

// file: sim/testbench.sv
// Purpose: self-checking bench for stack and operand addressing
// Assumes: ops issued only while op_ready is high
// Notes: stack contents modelled with a queue
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, op_valid, op_ready, bus_we, rf_we, pop_valid, pc_load, flags_load;
  stack_addr_pkg::stack_op_e op;
  logic [7:0] push_data, flags_in, rf_rdata, bus_addr, bus_wdata, bus_rdata, rf_addr;
  logic [7:0] rf_wdata, pop_data, flags_value, stack_top_pointer, work_byte, reg_byte;
  logic [15:0] pc_next_in, op_imm, pc_value, work_pair, reg_pair, got_pc, pc, t;
  stack_addr_pkg::operand_req_s req;
  stack_addr_pkg::operand_res_s res;
  integer errors, num_checks, seed, i, sp_m, lat_pc, lat_fl, lat_pop;
  logic [7:0] got_fl, got_pop, d, fl;
  logic [7:0] stk[$];
  logic [7:0] dt[4] = '{8'h80, 8'h7F, 8'h00, 8'h10};
  // ==========================================
  // design and partner
  stack_addr_unit dut (.clk, .rst, .op, .op_valid, .op_ready, .push_data, .pc_next_in,
    .op_imm, .flags_in, .rf_rdata, .bus_addr, .bus_we, .bus_wdata, .bus_rdata, .rf_addr,
    .rf_we, .rf_wdata, .pop_valid, .pop_data, .pc_load, .pc_value, .flags_load,
    .flags_value, .stack_top_pointer, .operand_req(req), .work_byte, .work_pair,
    .reg_byte, .reg_pair, .operand_res(res));
  reg_file_model rfm (.clk, .rf_addr, .rf_we, .rf_wdata, .rf_rdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk
  task automatic test_done;
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic run(input stack_addr_pkg::stack_op_e o, input logic [15:0] imm);
    integer k;
    lat_pc = -1;
    lat_fl = -1;
    lat_pop = -1;
    @(negedge clk);
    op = o;
    op_imm = imm;
    op_valid = 1'b1;
    #1;
    chk("op_ready", 16'h1, op_ready);
    if (o == stack_addr_pkg::OP_PUSH) begin
      chk("push strobe", 16'h1, rf_we);
      chk("push addr", (sp_m - 1) & 255, rf_addr);
      chk("push data", push_data, rf_wdata);
    end
    for (k = 0; k < 8; k++) begin
      @(negedge clk);
      op_valid = 1'b0;
      if (pc_load === 1'b1 && lat_pc < 0) begin
        lat_pc = k;
        got_pc = pc_value;
      end
      if (flags_load === 1'b1 && lat_fl < 0) begin
        lat_fl = k;
        got_fl = flags_value;
      end
      if (pop_valid === 1'b1 && lat_pop < 0) begin
        lat_pop = k;
        got_pop = pop_data;
      end
    end
    chk("op_ready idle", 16'h1, op_ready);
  endtask : run
  task automatic bus_wr(input logic [7:0] v);
    @(negedge clk);
    bus_addr = stack_addr_pkg::STACK_TOP_POINTER_ADDR;
    bus_we = 1'b1;
    bus_wdata = v;
    @(negedge clk);
    bus_we = 1'b0;
    sp_m = v;
    chk("pointer", v, stack_top_pointer);
    chk("bus read", v, bus_rdata);
    bus_addr = 8'h20;
    #1;
    chk("unmapped read", 16'h0, bus_rdata);
  endtask : bus_wr
  task automatic oper(input stack_addr_pkg::addr_mode_e m, input stack_addr_pkg::ins_class_e c,
                      input logic lng);
    @(negedge clk);
    req.mode = m;
    req.ins = c;
    req.working = 1'b0;
    req.long_offset = lng;
    req.reg_field = $random(seed);
    req.imm = $random(seed);
    work_byte = $random(seed);
    work_pair = $random(seed);
    reg_byte = $random(seed);
    reg_pair = $random(seed);
    #1;
  endtask : oper
  // ==========================================
  // watchdog
  initial begin
    #200000;
    errors++;
    test_done();
  end
  // ==========================================
  // main sequence
  initial begin
    errors = 0;
    num_checks = 0;
    seed = 32'h186646f6;
    rst = 1'b1;
    op = stack_addr_pkg::OP_NONE;
    op_valid = 1'b0;
    {push_data, flags_in, bus_addr, bus_wdata, bus_we, work_byte, reg_byte} = '0;
    {pc_next_in, op_imm, work_pair, reg_pair} = '0;
    req = '0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk("reset ready", 16'h1, op_ready);
    chk("reset pc", 16'h0, pc_value);
    chk("reset pc load", 16'h0, pc_load);
    bus_wr(8'hB7);
    for (i = 0; i < 4; i++) begin
      push_data = $random(seed);
      run(stack_addr_pkg::OP_PUSH, 16'h0);
      sp_m--;
      stk.push_front(push_data);
      chk("pointer", sp_m, stack_top_pointer);
      chk("stack byte", stk[0], rfm.mem[sp_m]);
    end
    for (i = 0; i < 4; i++) begin
      run(stack_addr_pkg::OP_POP, 16'h0);
      d = stk.pop_front();
      sp_m++;
      chk("pop data", d, got_pop);
      chk("pop latency", 16'h0, lat_pop);
      chk("pointer", sp_m, stack_top_pointer);
    end
    pc = $random(seed);
    pc_next_in = pc;
    t = $random(seed);
    run(stack_addr_pkg::OP_CALL, t);
    chk("call target", t, got_pc);
    chk("call latency", 16'h1, lat_pc);
    chk("saved high", pc[15:8], rfm.mem[sp_m - 2]);
    chk("saved low", pc[7:0], rfm.mem[sp_m - 1]);
    sp_m -= 2;
    t = $random(seed);
    run(stack_addr_pkg::OP_JUMP, t);
    chk("jump target", t, got_pc);
    chk("jump latency", 16'h0, lat_pc);
    pc_next_in = $random(seed);
    run(stack_addr_pkg::OP_RET, 16'h0);
    sp_m += 2;
    chk("return pc", pc, got_pc);
    chk("return latency", 16'h2, lat_pc);
    chk("pointer", sp_m, stack_top_pointer);
    pc = $random(seed);
    pc_next_in = pc;
    fl = $random(seed);
    flags_in = fl;
    run(stack_addr_pkg::OP_INT, 16'h0);
    chk("int low", pc[7:0], rfm.mem[sp_m - 1]);
    chk("int high", pc[15:8], rfm.mem[sp_m - 2]);
    chk("int flags", fl, rfm.mem[sp_m - 3]);
    sp_m -= 3;
    chk("pointer", sp_m, stack_top_pointer);
    flags_in = ~fl;
    pc_next_in = ~pc;
    run(stack_addr_pkg::OP_INTERRUPT_EXIT_INSTRUCTION, 16'h0);
    sp_m += 3;
    chk("interrupt_exit_instruction flags", fl, got_fl);
    chk("interrupt_exit_instruction flags latency", 16'h1, lat_fl);
    chk("interrupt_exit_instruction pc", pc, got_pc);
    chk("interrupt_exit_instruction pc latency", 16'h3, lat_pc);
    chk("pointer", sp_m, stack_top_pointer);
    for (i = 0; i < 4; i++) begin
      pc = (i > 1) ? 16'hFFF8 : 16'($random(seed));
      pc_next_in = pc;
      d = $random(seed);
      run(stack_addr_pkg::OP_BRANCH, {d, dt[i]});
      chk("branch target", pc + {{8{dt[i][7]}}, dt[i]}, got_pc);
    end
    bus_wr(8'h00);
    push_data = $random(seed);
    run(stack_addr_pkg::OP_PUSH, 16'h0);
    chk("pointer wrap", 16'hFF, stack_top_pointer);
    @(negedge clk);
    op = stack_addr_pkg::OP_RET;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk("reset mid ready", 16'h1, op_ready);
    @(negedge clk);
    chk("no stale load", 16'h0, pc_load);
    oper(stack_addr_pkg::AM_REG, stack_addr_pkg::INS_GENERAL_MOVE, 1'b0);
    chk("register mode", req.reg_field, res.rf_addr);
    chk("register valid", 16'h1, res.rf_valid);
    oper(stack_addr_pkg::AM_WORK, stack_addr_pkg::INS_GENERAL_MOVE, 1'b0);
    chk("working mode", {4'hC, req.reg_field[3:0]}, res.rf_addr);
    oper(stack_addr_pkg::AM_POINTER, stack_addr_pkg::INS_GENERAL_MOVE, 1'b0);
    chk("pointer to file", reg_byte, res.rf_addr);
    @(negedge clk);
    req.working = 1'b1;
    #1;
    chk("working pointer file", work_byte, res.rf_addr);
    oper(stack_addr_pkg::AM_POINTER, stack_addr_pkg::INS_PROGRAM_MEMORY_LOAD, 1'b0);
    chk("pointer to memory", reg_pair, res.mem_addr);
    chk("memory valid", 16'h1, res.mem_valid);
    @(negedge clk);
    req.working = 1'b1;
    #1;
    chk("working pointer memory", work_pair, res.mem_addr);
    oper(stack_addr_pkg::AM_INDEX_RF, stack_addr_pkg::INS_GENERAL_MOVE, 1'b0);
    chk("indexed file", 8'(req.imm[7:0] + work_byte), res.rf_addr);
    oper(stack_addr_pkg::AM_INDEX_RF, stack_addr_pkg::INS_EXTERNAL_DATA_LOAD, 1'b0);
    chk("indexed file refused", 16'h1, res.illegal);
    oper(stack_addr_pkg::AM_INDEX_MEM, stack_addr_pkg::INS_GENERAL_MOVE, 1'b0);
    chk("indexed memory refused", 16'h1, res.illegal);
    oper(stack_addr_pkg::AM_INDEX_MEM, stack_addr_pkg::INS_EXTERNAL_DATA_LOAD, 1'b0);
    chk("short index", work_pair + {{8{req.imm[7]}}, req.imm[7:0]}, res.mem_addr);
    oper(stack_addr_pkg::AM_INDEX_MEM, stack_addr_pkg::INS_PROGRAM_MEMORY_LOAD, 1'b1);
    chk("long index", work_pair + req.imm, res.mem_addr);
    oper(stack_addr_pkg::AM_DIRECT, stack_addr_pkg::INS_PROGRAM_MEMORY_LOAD, 1'b0);
    chk("direct", req.imm, res.mem_addr);
    oper(stack_addr_pkg::AM_LITERAL, stack_addr_pkg::INS_GENERAL_MOVE, 1'b0);
    chk("literal", req.imm[7:0], res.lit);
    chk("literal valid", 16'h1, res.lit_valid);
    test_done();
  end
endmodule : testbench
`default_nettype wire
